// ==== hw/rbs_reset_boot_sync.sv ====
// reset release, self-test, boot source and modulator sync control
`timescale 1ns/100ps
module rbs_reset_boot_sync #(
  parameter int POWER_UP_TEST_RESULT_CYCLES = rbs_pkg::RBS_POWER_UP_TEST_RESULT_CYCLES,
  parameter int OWR_CYCLES = rbs_pkg::RBS_OWR_CYCLES,
  parameter int MCLK_HALF = rbs_pkg::RBS_MCLK_HALF,
  parameter logic [7:0] FILTER_START_CMD = rbs_pkg::RBS_CMD_FILTER_START_DEF
) (
  input wire logic clk_in, // master clock, 200 MHz
  input wire logic rst_in, // synchronous reset, active high
  input wire logic reset_pin_n_in, // reset pin, active low, asynchronous
  input wire logic boot_sel_in, // boot select pin, asynchronous
  input wire logic sync_in, // sync pin, rising edge, asynchronous
  input wire logic [rbs_pkg::RBS_NUM_TESTS-1:0] test_fail_in, // per-test fail flags
  input wire logic cfg_wr_in, // configuration write strobe
  input wire logic [rbs_pkg::RBS_ADDR_W-1:0] cfg_addr_in, // register offset
  input wire logic [rbs_pkg::RBS_DATA_W-1:0] cfg_wdata_in, // write data
  output logic [rbs_pkg::RBS_DATA_W-1:0] cfg_rdata_out, // read data, one cycle late
  output logic cfg_ready_out, // high while commands are serviced
  output logic boot_mode_out, // captured boot select
  output logic filter_run_out, // filter operation started
  output logic mclk_out, // modulator clock
  output logic align_pulse_out, // modulator alignment pulse pin
  output logic phase_restart_out, // pulse: restart filter phase
  output logic sample_strobe_out, // pulse: output word due
  output logic ee_cs_n_out, // eeprom chip select, active low
  output logic ee_sck_out, // eeprom serial clock
  output logic ee_mosi_out, // eeprom serial data out
  output logic ee_oe_out, // high while eeprom pins are driven
  input wire logic ee_miso_in // eeprom serial data in
);
  import rbs_pkg::*;

  // pin synchronisers
  logic rstn_s1, rstn_s2, boot_s1, boot_s2, sync_s1, sync_s2, sync_s3;
  logic int_rst;

  // control state
  rbs_state_t st_reg, st_next;
  logic boot_mode_reg, boot_mode_next;
  logic [23:0] stcnt_reg, stcnt_next;
  logic [23:0] result_reg, result_next;
  logic [23:0] cfg_reg, cfg_next, user_a_reg, user_a_next, user_b_reg, user_b_next;
  logic [7:0] cmd_reg, cmd_next, eaddr_reg, eaddr_next;
  logic [3:0] words_reg, words_next;
  logic [1:0] bidx_reg, bidx_next;
  logic [23:0] acc_reg, acc_next, rdata_reg, rdata_next;
  logic pend_reg, pend_next;

  // eeprom reader link
  logic ee_start, ee_ready, ee_req, ee_bv;
  logic [7:0] ee_byte;

  // register write path shared by host and eeprom boot
  logic host_ok, ee_wr, wr_en;
  logic [7:0] wr_addr;
  logic [23:0] wr_data, ee_word;

  // sync path
  logic [7:0] mdiv_reg, mdiv_next;
  logic mclk_reg, mclk_next, seen_reg, seen_next, armed_reg, armed_next;
  logic pulse_reg, pulse_next, restart_reg, restart_next, strobe_reg, strobe_next;
  logic [19:0] phase_reg, phase_next;
  logic mtick, mrise, mfall, sync_edge, align_en, run;

  // two stages on every pin before any logic looks at it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rstn_s1 <= 1'b0;
      rstn_s2 <= 1'b0;
    end else begin
      rstn_s1 <= reset_pin_n_in;
      rstn_s2 <= rstn_s1;
    end
    boot_s1 <= boot_sel_in;
    boot_s2 <= boot_s1;
    sync_s1 <= sync_in;
    sync_s2 <= sync_s1;
    sync_s3 <= sync_s2;
  end

  // a low pin holds everything, so a reset mid boot restarts the lot
  assign int_rst = rst_in | ~rstn_s2;

  // commands are only honoured once self-test is over and no boot is running
  assign host_ok = (st_reg == RBS_ST_IDLE) || (st_reg == RBS_ST_RUN);
  assign ee_word = {acc_reg[15:0], ee_byte};
  assign ee_wr = ee_bv && (st_reg == RBS_ST_BOOT_DATA) && (bidx_reg == RBS_LAST_BYTE) &&
                 (cmd_reg == RBS_CMD_WRITE_REG) && (words_reg == 4'h1);
  assign wr_en = (host_ok && cfg_wr_in) || ee_wr;
  assign wr_addr = ee_wr ? eaddr_reg : cfg_addr_in;
  assign wr_data = ee_wr ? ee_word : cfg_wdata_in;
  assign ee_start = (st_reg == RBS_ST_BOOT_CMD) || (st_reg == RBS_ST_BOOT_DATA);
  assign ee_req = ee_start && ee_ready && !pend_reg;

  // boot sequencer, register file and eeprom command parser
  always_comb begin
    st_next = st_reg;
    boot_mode_next = boot_mode_reg;
    stcnt_next = stcnt_reg;
    result_next = result_reg;
    cfg_next = cfg_reg;
    user_a_next = user_a_reg;
    user_b_next = user_b_reg;
    cmd_next = cmd_reg;
    eaddr_next = eaddr_reg;
    words_next = words_reg;
    bidx_next = bidx_reg;
    acc_next = acc_reg;
    pend_next = (pend_reg | ee_req) & ~ee_bv;
    if (wr_en) begin
      case (wr_addr)
        RBS_OFS_CONFIG: cfg_next = wr_data;
        RBS_OFS_USER_A: user_a_next = wr_data;
        RBS_OFS_USER_B: user_b_next = wr_data;
        default: ;
      endcase
    end
    case (st_reg)
      RBS_ST_RESET: begin
        boot_mode_next = boot_s2;
        stcnt_next = 24'h000000;
        st_next = RBS_ST_POWER_UP_TEST_RESULT;
      end
      RBS_ST_POWER_UP_TEST_RESULT: begin
        stcnt_next = stcnt_reg + 24'h000001;
        if (stcnt_reg == 24'(POWER_UP_TEST_RESULT_CYCLES - 1)) begin
          result_next = rbs_result(test_fail_in);
          st_next = boot_mode_reg ? RBS_ST_BOOT_CMD : RBS_ST_IDLE;
        end
      end
      RBS_ST_BOOT_CMD: begin
        if (ee_bv) begin
          cmd_next = ee_byte;
          words_next = rbs_words_for(ee_byte);
          bidx_next = 2'h0;
          if (ee_byte == FILTER_START_CMD) begin
            cfg_next[RBS_CFG_RUN_BIT] = 1'b1;
            st_next = RBS_ST_RUN;
          end else if (rbs_words_for(ee_byte) != 4'h0) begin
            st_next = RBS_ST_BOOT_DATA;
          end
        end
      end
      RBS_ST_BOOT_DATA: begin
        if (ee_bv) begin
          acc_next = ee_word;
          bidx_next = bidx_reg + 2'h1;
          if (bidx_reg == RBS_LAST_BYTE) begin
            bidx_next = 2'h0;
            words_next = words_reg - 4'h1;
            // first word of a register write carries the target offset
            if (cmd_reg == RBS_CMD_WRITE_REG && words_reg == RBS_WORDS_WRITE_REG) begin
              eaddr_next = ee_byte;
            end
            if (words_reg == 4'h1) begin
              st_next = RBS_ST_BOOT_CMD;
            end
          end
        end
      end
      RBS_ST_IDLE: begin
        if (cfg_reg[RBS_CFG_RUN_BIT]) begin
          st_next = RBS_ST_RUN;
        end
      end
      RBS_ST_RUN: ;
      default: st_next = RBS_ST_RESET;
    endcase
    case (cfg_addr_in)
      RBS_OFS_CONFIG: rdata_next = cfg_reg;
      RBS_OFS_USER_A: rdata_next = user_a_reg;
      RBS_OFS_USER_B: rdata_next = user_b_reg;
      RBS_OFS_RESULT: rdata_next = result_reg;
      default: rdata_next = 24'h000000;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (int_rst) begin
      st_reg <= RBS_ST_RESET;
      boot_mode_reg <= 1'b0;
      stcnt_reg <= 24'h000000;
      result_reg <= 24'h000000;
      cfg_reg <= RBS_CONFIG_RST;
      user_a_reg <= RBS_USER_RST;
      user_b_reg <= RBS_USER_RST;
      cmd_reg <= 8'h00;
      eaddr_reg <= 8'h00;
      words_reg <= 4'h0;
      bidx_reg <= 2'h0;
      acc_reg <= 24'h000000;
      pend_reg <= 1'b0;
      rdata_reg <= 24'h000000;
    end else begin
      st_reg <= st_next;
      boot_mode_reg <= boot_mode_next;
      stcnt_reg <= stcnt_next;
      result_reg <= result_next;
      cfg_reg <= cfg_next;
      user_a_reg <= user_a_next;
      user_b_reg <= user_b_next;
      cmd_reg <= cmd_next;
      eaddr_reg <= eaddr_next;
      words_reg <= words_next;
      bidx_reg <= bidx_next;
      acc_reg <= acc_next;
      pend_reg <= pend_next;
      rdata_reg <= rdata_next;
    end
  end

  // eeprom master; it is idle and its pins released outside the boot states
  rbs_ee_reader u_ee (
    .clk_in(clk_in),
    .rst_in(int_rst),
    .start_in(ee_start),
    .byte_req_in(ee_req),
    .ready_out(ee_ready),
    .byte_out(ee_byte),
    .byte_valid_out(ee_bv),
    .cs_n_out(ee_cs_n_out),
    .sck_out(ee_sck_out),
    .mosi_out(ee_mosi_out),
    .oe_out(ee_oe_out),
    .miso_in(ee_miso_in)
  );

  // modulator clock events and sync retiming
  assign mtick = (mdiv_reg == 8'(MCLK_HALF - 1));
  assign mrise = mtick && !mclk_reg;
  assign mfall = mtick && mclk_reg;
  assign sync_edge = sync_s2 && !sync_s3;
  assign align_en = cfg_reg[RBS_CFG_ALIGN_EN_BIT];
  assign run = cfg_reg[RBS_CFG_RUN_BIT];

  always_comb begin
    mdiv_next = mtick ? 8'h00 : mdiv_reg + 8'h01;
    mclk_next = mtick ? ~mclk_reg : mclk_reg;
    // an edge in the same cycle as the hand-off is kept, not lost
    seen_next = sync_edge | (seen_reg & ~mrise);
    armed_next = armed_reg;
    pulse_next = pulse_reg;
    restart_next = 1'b0;
    if (mrise) begin
      armed_next = seen_reg;
    end
    if (mfall) begin
      // launched on the falling edge and held one full modulator period
      pulse_next = armed_reg & align_en;
      restart_next = armed_reg & align_en;
      armed_next = 1'b0;
    end
    phase_next = run ? phase_reg + 20'h00001 : phase_reg;
    if (phase_reg == 20'(OWR_CYCLES - 1)) begin
      phase_next = 20'h00000;
    end
    // a restart that lands on the wrap finds the phase already at zero
    if (mfall && armed_reg && align_en) begin
      phase_next = 20'h00000;
    end
    strobe_next = run && (phase_reg == 20'(OWR_CYCLES - 1)) && !(mfall && armed_reg && align_en);
  end

  always_ff @(posedge clk_in) begin
    if (int_rst) begin
      mdiv_reg <= 8'h00;
      mclk_reg <= 1'b0;
      seen_reg <= 1'b0;
      armed_reg <= 1'b0;
      pulse_reg <= 1'b0;
      restart_reg <= 1'b0;
      phase_reg <= 20'h00000;
      strobe_reg <= 1'b0;
    end else begin
      mdiv_reg <= mdiv_next;
      mclk_reg <= mclk_next;
      seen_reg <= seen_next;
      armed_reg <= armed_next;
      pulse_reg <= pulse_next;
      restart_reg <= restart_next;
      phase_reg <= phase_next;
      strobe_reg <= strobe_next;
    end
  end

  assign cfg_rdata_out = rdata_reg;
  assign cfg_ready_out = host_ok;
  assign boot_mode_out = boot_mode_reg;
  assign filter_run_out = run;
  assign mclk_out = mclk_reg;
  assign align_pulse_out = pulse_reg;
  assign phase_restart_out = restart_reg;
  assign sample_strobe_out = strobe_reg;

  // checks
  sequence s_release;
    (st_reg == RBS_ST_RESET) && !int_rst;
  endsequence

  sequence s_test_end;
    (st_reg == RBS_ST_POWER_UP_TEST_RESULT) && (stcnt_reg == 24'(POWER_UP_TEST_RESULT_CYCLES - 1)) && !int_rst;
  endsequence

  property p_reset_holds;
    @(posedge clk_in) int_rst |=> (st_reg == RBS_ST_RESET) && !filter_run_out;
  endproperty
  a_reset_holds: assert property (p_reset_holds) else $error("reset not holding");

  property p_release_to_test;
    @(posedge clk_in) disable iff (int_rst) s_release |=> (st_reg == RBS_ST_POWER_UP_TEST_RESULT);
  endproperty
  a_release_to_test: assert property (p_release_to_test) else $error("no self-test");

  property p_boot_capture;
    @(posedge clk_in) disable iff (int_rst) s_release |=> boot_mode_reg == $past(boot_s2);
  endproperty
  a_boot_capture: assert property (p_boot_capture) else $error("boot select lost");

  property p_result_code;
    @(posedge clk_in) disable iff (int_rst)
      s_test_end |=> result_reg == rbs_result($past(test_fail_in));
  endproperty
  a_result_code: assert property (p_result_code) else $error("bad result word");

  property p_no_early_cmd;
    @(posedge clk_in) disable iff (int_rst)
      (st_reg == RBS_ST_POWER_UP_TEST_RESULT) && cfg_wr_in |=> $stable(user_a_reg) && $stable(cfg_reg);
  endproperty
  a_no_early_cmd: assert property (p_no_early_cmd) else $error("command during test");

  property p_mcu_idle;
    @(posedge clk_in) disable iff (int_rst)
      s_test_end ##0 !boot_mode_reg |=> (st_reg == RBS_ST_IDLE) && !ee_oe_out;
  endproperty
  a_mcu_idle: assert property (p_mcu_idle) else $error("mcu boot not idle");

  property p_user_store;
    @(posedge clk_in) disable iff (int_rst)
      host_ok && cfg_wr_in && (cfg_addr_in == RBS_OFS_USER_B) |=> user_b_reg == $past(cfg_wdata_in);
  endproperty
  a_user_store: assert property (p_user_store) else $error("user word not stored");

  property p_pulse_gated;
    @(posedge clk_in) disable iff (int_rst) $rose(pulse_reg) |-> $past(align_en) && $past(mclk_reg);
  endproperty
  a_pulse_gated: assert property (p_pulse_gated) else $error("pulse while disabled");

  property p_restart_phase;
    @(posedge clk_in) disable iff (int_rst)
      $rose(pulse_reg) |-> restart_reg && (phase_reg == 20'h00000) ##1 !restart_reg;
  endproperty
  a_restart_phase: assert property (p_restart_phase) else $error("phase not restarted");
endmodule

// ==== hw/rbs_pkg.sv ====
// constants, types and helpers shared by the reset, boot and sync control block
package rbs_pkg;
  localparam int RBS_DATA_W = 24;
  localparam int RBS_ADDR_W = 8;
  localparam logic [7:0] RBS_OFS_CONFIG = 8'h00;
  localparam logic [7:0] RBS_OFS_USER_A = 8'h2C;
  localparam logic [7:0] RBS_OFS_USER_B = 8'h2D;
  localparam logic [7:0] RBS_OFS_RESULT = 8'h2F;
  localparam logic [23:0] RBS_CONFIG_RST = 24'h000000;
  localparam logic [23:0] RBS_USER_RST = 24'h000000;
  localparam int RBS_CFG_ALIGN_EN_BIT = 0;
  localparam int RBS_CFG_RUN_BIT = 1;
  // self-test result coding
  localparam int RBS_NUM_TESTS = 5;
  localparam logic [3:0] RBS_PASS_CODE = 4'hA;
  localparam logic [3:0] RBS_FAIL_CODE = 4'hF;
  localparam logic [23:0] RBS_ALL_PASS = 24'h0AAAAA;
  // timing
  localparam int RBS_CLK_KHZ = 200000;
  localparam int RBS_POWER_UP_TEST_RESULT_MS = 60;
  localparam int RBS_POWER_UP_TEST_RESULT_CYCLES = RBS_POWER_UP_TEST_RESULT_MS * RBS_CLK_KHZ;
  localparam int RBS_SCK_KHZ = 1024;
  localparam int RBS_SCK_HALF = RBS_CLK_KHZ / (2 * RBS_SCK_KHZ);
  localparam int RBS_MCLK_KHZ = 2048;
  localparam int RBS_MCLK_HALF = RBS_CLK_KHZ / (2 * RBS_MCLK_KHZ);
  localparam int RBS_OWR_SPS = 500;
  localparam int RBS_OWR_CYCLES = RBS_CLK_KHZ * 1000 / RBS_OWR_SPS;
  // serial EEPROM boot
  localparam logic [7:0] RBS_EE_READ_OP = 8'h03;
  localparam logic [15:0] RBS_EE_START = 16'h0010;
  localparam int RBS_EE_HDR_BITS = 24;
  localparam int RBS_EE_BYTE_BITS = 8;
  localparam logic [7:0] RBS_CMD_WRITE_REG = 8'h01;
  localparam logic [7:0] RBS_CMD_IIR = 8'h03;
  localparam logic [7:0] RBS_CMD_ROM = 8'h04;
  localparam logic [7:0] RBS_CMD_FILTER_START_DEF = 8'hFF;
  localparam logic [3:0] RBS_WORDS_WRITE_REG = 4'h2;
  localparam logic [3:0] RBS_WORDS_IIR = 4'h8;
  localparam logic [3:0] RBS_WORDS_ROM = 4'h1;
  localparam logic [1:0] RBS_LAST_BYTE = 2'h2;

  typedef enum logic [5:0] {
    RBS_ST_RESET = 6'h01,
    RBS_ST_POWER_UP_TEST_RESULT = 6'h02,
    RBS_ST_BOOT_CMD = 6'h04,
    RBS_ST_BOOT_DATA = 6'h08,
    RBS_ST_IDLE = 6'h10,
    RBS_ST_RUN = 6'h20
  } rbs_state_t;

  typedef enum logic [3:0] {
    RBS_EE_IDLE = 4'h1,
    RBS_EE_SEND = 4'h2,
    RBS_EE_WAIT = 4'h4,
    RBS_EE_RECV = 4'h8
  } rbs_ee_state_t;

  // one nibble per test, upper nibble stays zero
  function automatic logic [23:0] rbs_result(input logic [RBS_NUM_TESTS-1:0] fail);
    logic [23:0] r;
    r = 24'h000000;
    for (int i = 0; i < RBS_NUM_TESTS; i++) begin
      r[i*4 +: 4] = fail[i] ? RBS_FAIL_CODE : RBS_PASS_CODE;
    end
    return r;
  endfunction

  // number of 3-byte data words behind a boot command; zero means none
  function automatic logic [3:0] rbs_words_for(input logic [7:0] cmd);
    logic [3:0] n;
    case (cmd)
      RBS_CMD_WRITE_REG: n = RBS_WORDS_WRITE_REG;
      RBS_CMD_IIR: n = RBS_WORDS_IIR;
      RBS_CMD_ROM: n = RBS_WORDS_ROM;
      default: n = 4'h0;
    endcase
    return n;
  endfunction
endpackage

// ==== hw/rbs_ee_reader.sv ====
// serial EEPROM streaming reader used during EEPROM boot
`timescale 1ns/100ps
module rbs_ee_reader #(
  parameter int HALF = rbs_pkg::RBS_SCK_HALF
) (
  input wire logic clk_in, // system clock
  input wire logic rst_in, // synchronous reset, active high
  input wire logic start_in, // level: hold high for the whole boot read
  input wire logic byte_req_in, // pulse: fetch the next byte
  output logic ready_out, // header sent, waiting for a byte request
  output logic [7:0] byte_out, // last byte read
  output logic byte_valid_out, // pulse: byte_out is new
  output logic cs_n_out, // chip select, active low
  output logic sck_out, // serial clock
  output logic mosi_out, // serial data to eeprom
  output logic oe_out, // high while the serial pins are driven
  input wire logic miso_in // serial data from eeprom, asynchronous
);
  import rbs_pkg::*;

  rbs_ee_state_t st_reg, st_next;
  logic [7:0] div_reg, div_next;
  logic sck_reg, sck_next;
  logic [23:0] sh_reg, sh_next;
  logic [4:0] bit_reg, bit_next;
  logic bv_reg, bv_next;
  logic miso_s1, miso_s2;

  // pin synchroniser; bits are taken long after the eeprom launched them
  always_ff @(posedge clk_in) begin
    miso_s1 <= miso_in;
    miso_s2 <= miso_s1;
  end

  // one continuous read: opcode and start address, then bytes on demand
  always_comb begin
    st_next = st_reg;
    div_next = div_reg;
    sck_next = sck_reg;
    sh_next = sh_reg;
    bit_next = bit_reg;
    bv_next = 1'b0;
    case (st_reg)
      RBS_EE_IDLE: begin
        sck_next = 1'b0;
        if (start_in) begin
          st_next = RBS_EE_SEND;
          sh_next = {RBS_EE_READ_OP, RBS_EE_START};
          bit_next = 5'(RBS_EE_HDR_BITS);
          div_next = 8'h00;
        end
      end
      RBS_EE_SEND, RBS_EE_RECV: begin
        if (div_reg == 8'(HALF - 1)) begin
          div_next = 8'h00;
          sck_next = ~sck_reg;
          // falling edge: capture the bit held since the rising edge, launch the next
          if (sck_reg) begin
            sh_next = {sh_reg[22:0], miso_s2};
            bit_next = bit_reg - 5'h01;
            if (bit_reg == 5'h01) begin
              st_next = RBS_EE_WAIT;
              bv_next = (st_reg == RBS_EE_RECV);
            end
          end
        end else begin
          div_next = div_reg + 8'h01;
        end
      end
      RBS_EE_WAIT: begin
        if (byte_req_in) begin
          st_next = RBS_EE_RECV;
          bit_next = 5'(RBS_EE_BYTE_BITS);
          div_next = 8'h00;
        end
      end
      default: st_next = RBS_EE_IDLE;
    endcase
    // dropping start ends the transaction at once, even mid byte
    if (!start_in) begin
      st_next = RBS_EE_IDLE;
      sck_next = 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_reg <= RBS_EE_IDLE;
      div_reg <= 8'h00;
      sck_reg <= 1'b0;
      sh_reg <= 24'h000000;
      bit_reg <= 5'h00;
      bv_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      div_reg <= div_next;
      sck_reg <= sck_next;
      sh_reg <= sh_next;
      bit_reg <= bit_next;
      bv_reg <= bv_next;
    end
  end

  assign ready_out = (st_reg == RBS_EE_WAIT);
  assign byte_out = sh_reg[7:0];
  assign byte_valid_out = bv_reg;
  assign cs_n_out = (st_reg == RBS_EE_IDLE);
  assign sck_out = sck_reg;
  assign mosi_out = sh_reg[23];
  assign oe_out = (st_reg != RBS_EE_IDLE);
endmodule

// ==== dv/rbs_ee_model.sv ====
// serial eeprom model holding a short boot image
`timescale 1ns/100ps
module rbs_ee_model (
  input wire logic cs_n_in, // chip select, active low
  input wire logic sck_in, // serial clock
  input wire logic mosi_in, // serial data in
  output logic miso_out, // serial data out
  output logic [23:0] hdr_out // opcode and address seen
);
  logic [7:0] img [0:7] = '{8'h01, 8'h00, 8'h00, 8'h2C, 8'h12, 8'h34, 8'h56, 8'hFF};
  int cnt = 0;
  initial miso_out = 1'b0;
  // header is taken on rising sck; deselect clears the bit count here only
  always @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      cnt <= 0;
    end else begin
      if (cnt < 24) hdr_out <= {hdr_out[22:0], mosi_in};
      cnt <= cnt + 1;
    end
  end
  // data moves on falling sck; idle gives a toggled level so a stale bit is never read
  always @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in || cnt < 24 || cnt >= 88) begin
      miso_out <= ~miso_out;
    end else begin
      miso_out <= img[(cnt - 24) / 8][7 - (cnt - 24) % 8];
    end
  end
endmodule

// ==== dv/reset_boot_sync_control_tb.sv ====
// self-checking bench for the reset, boot and sync control block
`timescale 1ns/100ps
module reset_boot_sync_control_tb;
  import rbs_pkg::*;
  localparam int OWR = 50;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic pin_n = 1'b0;
  logic boot = 1'b0;
  logic sync = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [23:0] wdata = 24'h000000;
  logic [23:0] rdata, hdr;
  logic ready, mode, run, restart, pulse, strobe, cs_n, sck, mosi, oe, miso, mclk;
  // per-test fail flags standing in for the self-test engines
  logic [4:0] fails = 5'h05;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_rst = 0;
  int t;
  always #2.5 clk_in = ~clk_in;
  rbs_reset_boot_sync #(.POWER_UP_TEST_RESULT_CYCLES(200), .OWR_CYCLES(OWR)) dut (
    .clk_in(clk_in), .rst_in(rst_in), .reset_pin_n_in(pin_n), .boot_sel_in(boot),
    .sync_in(sync), .test_fail_in(fails), .cfg_wr_in(wr), .cfg_addr_in(addr),
    .cfg_wdata_in(wdata), .cfg_rdata_out(rdata), .cfg_ready_out(ready),
    .boot_mode_out(mode), .filter_run_out(run), .mclk_out(mclk),
    .align_pulse_out(pulse), .phase_restart_out(restart), .sample_strobe_out(strobe),
    .ee_cs_n_out(cs_n), .ee_sck_out(sck), .ee_mosi_out(mosi), .ee_oe_out(oe),
    .ee_miso_in(miso));
  rbs_ee_model ee (.cs_n_in(oe ? cs_n : 1'b1), .sck_in(oe & sck), .mosi_in(mosi),
    .miso_out(miso), .hdr_out(hdr));
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [23:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(posedge clk_in) #1;
    wr = 1'b0;
    // one idle cycle so back-to-back calls never reassign wr in one step
    @(posedge clk_in) #1;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [23:0] exp);
    addr = a;
    @(posedge clk_in) #1;
    chk(rdata, exp);
  endtask
  // bounded wait; t holds the cycles spent
  task automatic wait_hi(ref logic s, input int lim);
    t = 0;
    while (s !== 1'b1 && t < lim) begin
      @(posedge clk_in) #1;
      t++;
    end
    // a wait that runs out counts as a mismatch
    if (s !== 1'b1) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, s, 1'b1);
    end
  endtask
  // pin reset, boot level held a while after release, then flipped to show it is latched
  task automatic power_up(input logic b);
    pin_n = 1'b0;
    repeat (4) @(posedge clk_in) #1;
    boot = b;
    pin_n = 1'b1;
    repeat (8) @(posedge clk_in) #1;
    boot = ~b;
  endtask
  task automatic sync_edge();
    sync = 1'b1;
    repeat (4) @(posedge clk_in) #1;
    sync = 1'b0;
  endtask
  // cycle count, restart pulse count and hang guard; falling edge sees settled outputs
  always @(negedge clk_in) begin
    cyc++;
    if (restart === 1'b1) n_rst++;
    if (cyc == 60000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge clk_in) #1;
    rst_in = 1'b0;
    power_up(1'b0);
    wr_reg(RBS_OFS_USER_A, 24'h111111);
    wait_hi(ready, 400);
    chk(24'(ready & (t > 180)), 24'h1);
    chk(24'(mode), 24'h0);
    rd_reg(RBS_OFS_USER_A, 24'h0);
    rd_reg(RBS_OFS_RESULT, 24'h0AAFAF);
    wr_reg(RBS_OFS_RESULT, 24'h0);
    rd_reg(RBS_OFS_RESULT, 24'h0AAFAF);
    wr_reg(RBS_OFS_USER_A, 24'hFFFFFF);
    wr_reg(RBS_OFS_USER_B, 24'h000001);
    rd_reg(RBS_OFS_USER_A, 24'hFFFFFF);
    rd_reg(RBS_OFS_USER_B, 24'h000001);
    rd_reg(8'h2E, 24'h0);
    sync_edge();
    repeat (400) @(posedge clk_in) #1;
    chk(24'(n_rst), 24'h0);
    wr_reg(RBS_OFS_CONFIG, 24'h000003);
    sync_edge();
    wait_hi(restart, 400);
    chk(24'(pulse), 24'h1);
    chk(24'(mclk), 24'h0);
    wait_hi(strobe, 100);
    chk(24'(t), 24'(OWR));
    chk(24'(run), 24'h1);
    chk(24'(n_rst), 24'h1);
    power_up(1'b0);
    repeat (100) @(posedge clk_in) #1;
    fails = 5'h00;
    power_up(1'b1);
    wait_hi(run, 40000);
    chk(24'(mode), 24'h1);
    chk(hdr, {RBS_EE_READ_OP, 16'h0010});
    rd_reg(RBS_OFS_USER_A, 24'h123456);
    rd_reg(RBS_OFS_USER_B, 24'h0);
    rd_reg(RBS_OFS_RESULT, RBS_ALL_PASS);
    conclude();
  end
endmodule
